// ### hdl/can_glb_pkg.sv
// Shared constants for the CAN global receive and timing block
package can_glb_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CFG_LOW = 8'h00;
  localparam logic [7:0] OFS_CFG_HIGH = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_CH_CFG = 8'h0c;
  localparam logic [7:0] OFS_FIFO_IV = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // ==========================================================
  // Field positions
  localparam int B_DLC_CHECK = 0;
  localparam int B_DLC_REPLACE = 1;
  localparam int B_MIRROR = 2;
  localparam int B_CLK_SEL = 3;
  localparam int B_TS_SRC = 4;
  localparam int B_TS_PRESCALE = 8;
  localparam int B_GRST = 0;
  localparam int B_CHRUN = 1;
  localparam int B_BAUD_PRE = 0;
  localparam int B_TQB = 16;
  localparam int B_STAT_GRST = 16;

  // ==========================================================
  // Writable bits of each register
  localparam logic [31:0] MASK_CFG_LOW = 32'h0000_0f1f;
  localparam logic [31:0] MASK_CFG_HIGH = 32'h0000_ffff;
  localparam logic [31:0] MASK_CTRL = 32'h0000_0003;
  localparam logic [31:0] MASK_CH_CFG = 32'h001f_03ff;
  localparam logic [31:0] MASK_FIFO_IV = 32'h0000_00ff;

  // ==========================================================
  // Values after reset
  localparam logic [31:0] RST_CFG_LOW = 32'h0000_0000;
  localparam logic [31:0] RST_CFG_HIGH = 32'h0000_0001;
  localparam logic [31:0] RST_CTRL = 32'h0000_0001;
  localparam logic [31:0] RST_CH_CFG = 32'h0008_0000;
  localparam logic [31:0] RST_FIFO_IV = 32'h0000_0000;

  // ==========================================================
  // Message and timing field widths
  localparam int DLC_W = 4;
  localparam int TS_W = 16;
  localparam int DATA_W = 64;
  localparam int NBYTES = 8;
  localparam int BAUD_PRE_W = 10;
  localparam int TQB_W = 5;

endpackage

// ### hdl/can_tick_div.sv
// Enable-pulse divider: one tick out per (ratio_m1 + 1) ticks in
`timescale 1ns/1ps
module can_tick_div (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Source and ratio
  input wire logic src_tick,
  input wire logic [15:0] ratio_m1,
  // Divided pulse
  output logic tick
);

  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } div_state_t;

  div_state_t st;
  div_state_t next_st;

  // ==========================================================
  // Counter
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (src_tick) begin
      if (st.cnt >= ratio_m1) begin
        next_st.cnt = 16'h0000;
        next_st.tick = 1'b1;
      end else begin
        next_st.cnt = st.cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;

endmodule // can_tick_div

// ### hdl/can_global_rx.sv
// CAN global functions: DLC filter, mirror select, clock source, timestamp, interval (stopped while the timestamp source is the bit clock)
//
// Decided for this implementation: the address map and the Wishbone slave port.
`timescale 1ns/1ps

module can_global_rx (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Wishbone slave
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  // External oscillator level
  input wire logic x1_clk,
  // Received message after acceptance filtering
  input wire logic msg_sof,
  input wire logic msg_valid,
  input wire logic msg_self,
  input wire logic [3:0] msg_dlc,
  input wire logic [63:0] msg_data,
  input wire logic rule_hit,
  input wire logic rule_self_rx_select,
  input wire logic [3:0] rule_dlc_value,
  // Store request
  output logic store_valid,
  output logic [3:0] store_dlc,
  output logic [63:0] store_data,
  output logic [15:0] store_stamp,
  output logic dlc_error,
  // Timing pulses
  output logic channel_quantum_clock,
  output logic bit_tick,
  output logic interval_tick
);

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [31:0] global_config_low;
    logic [31:0] global_config_high;
    logic [31:0] ctrl;
    logic [31:0] channel_config_low;
    logic [31:0] txrx_fifo_control_high;
    logic half;
    logic x1_q;
    logic [15:0] stamp;
    logic [15:0] sof_stamp;
    logic st_valid;
    logic [3:0] st_dlc;
    logic [63:0] st_data;
    logic [15:0] st_stamp;
    logic dlc_err;
  } rx_state_t;

  rx_state_t st;
  rx_state_t next_st;

  // ==========================================================
  // Helpers
  function automatic logic [31:0] wb_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] sel, input logic [31:0] msk);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i+:8] = wd[8*i+:8];
      end
    end
    return (r & msk) | (old & ~msk);
  endfunction

  function automatic logic [63:0] keep_bytes(input logic [63:0] d, input logic [3:0] n);
    logic [63:0] r;
    r = 64'h0;
    for (int i = 0; i < can_glb_pkg::NBYTES; i++) begin
      if (4'(i) < n) begin
        r[8*i+:8] = d[8*i+:8];
      end
    end
    return r;
  endfunction

  // ==========================================================
  // Field views
  wire logic dlc_check_enable = st.global_config_low[can_glb_pkg::B_DLC_CHECK];
  wire logic dlc_replace_enable = st.global_config_low[can_glb_pkg::B_DLC_REPLACE];
  wire logic mirror_enable = st.global_config_low[can_glb_pkg::B_MIRROR];
  wire logic can_clock_select = st.global_config_low[can_glb_pkg::B_CLK_SEL];
  wire logic timestamp_source_select = st.global_config_low[can_glb_pkg::B_TS_SRC];
  wire logic [3:0] timestamp_prescale = st.global_config_low[can_glb_pkg::B_TS_PRESCALE+:4];
  wire logic grst = st.ctrl[can_glb_pkg::B_GRST];
  wire logic ch_run = st.ctrl[can_glb_pkg::B_CHRUN];
  wire logic [9:0] baud_prescaler_value =
    st.channel_config_low[can_glb_pkg::B_BAUD_PRE+:can_glb_pkg::BAUD_PRE_W];
  wire logic [4:0] tqb = st.channel_config_low[can_glb_pkg::B_TQB+:can_glb_pkg::TQB_W];

  // ==========================================================
  // Clock tree
  logic ts_tick;
  logic iv_pre_tick;
  wire logic half_tick = st.half;
  wire logic can_tick = can_clock_select ? (x1_clk && !st.x1_q) : half_tick;
  wire logic ts_src = timestamp_source_select ? (bit_tick && ch_run)
                                              : half_tick;
  wire logic [15:0] iv_ratio_m1 = st.global_config_high[15:0] - 16'h0001;
  wire logic [4:0] tqb_m1 = tqb - 5'h01;

  // Quantum clock: divide by prescaler value plus one
  can_tick_div u_quantum_div (
    .sys_clk(sys_clk), .rst_n(rst_n), .src_tick(can_tick),
    .ratio_m1({6'h00, baud_prescaler_value}), .tick(channel_quantum_clock)
  );
  // Bit clock: quanta per bit
  can_tick_div u_bit (
    .sys_clk(sys_clk), .rst_n(rst_n), .src_tick(channel_quantum_clock),
    .ratio_m1({11'h000, tqb_m1}), .tick(bit_tick)
  );
  can_tick_div u_stamp_div (
    .sys_clk(sys_clk), .rst_n(rst_n), .src_tick(ts_src),
    .ratio_m1({12'h000, timestamp_prescale}), .tick(ts_tick)
  );
  can_tick_div u_ivp (
    .sys_clk(sys_clk), .rst_n(rst_n), .src_tick(half_tick && !timestamp_source_select),
    .ratio_m1(iv_ratio_m1), .tick(iv_pre_tick)
  );
  can_tick_div u_ivf (
    .sys_clk(sys_clk), .rst_n(rst_n), .src_tick(iv_pre_tick),
    .ratio_m1({8'h00, st.txrx_fifo_control_high[7:0]}), .tick(interval_tick)
  );

  // ==========================================================
  // Receive decision
  wire logic eligible = msg_self ? (mirror_enable && rule_self_rx_select)
                                 : !rule_self_rx_select;
  wire logic accept = msg_valid && rule_hit && eligible;
  wire logic short_dlc = dlc_check_enable && (msg_dlc < rule_dlc_value)
                         && (rule_dlc_value != 4'h0);

  // ==========================================================
  // Next state
  wire logic req = wb_cyc && wb_stb && !st.ack;

  always_comb begin
    next_st = st;
    next_st.ack = req;
    next_st.half = !st.half;
    next_st.x1_q = x1_clk;
    next_st.st_valid = 1'b0;
    next_st.dlc_err = 1'b0;
    if (ts_tick && (!timestamp_source_select || ch_run)) begin
      next_st.stamp = st.stamp + 16'h0001;
    end
    if (msg_sof) begin
      next_st.sof_stamp = st.stamp;
    end
    if (accept) begin
      if (short_dlc) begin
        next_st.dlc_err = 1'b1;
      end else begin
        next_st.st_valid = 1'b1;
        next_st.st_stamp = st.sof_stamp;
        if (dlc_check_enable && dlc_replace_enable) begin
          next_st.st_dlc = rule_dlc_value;
          next_st.st_data = keep_bytes(msg_data, rule_dlc_value);
        end else begin
          next_st.st_dlc = msg_dlc;
          next_st.st_data = msg_data;
        end
      end
    end
    next_st.rdata = 32'h0;
    if (req && !wb_we) begin
      case (wb_adr)
        can_glb_pkg::OFS_CFG_LOW: next_st.rdata = st.global_config_low;
        can_glb_pkg::OFS_CFG_HIGH: next_st.rdata = st.global_config_high;
        can_glb_pkg::OFS_CTRL: next_st.rdata = st.ctrl;
        can_glb_pkg::OFS_CH_CFG: next_st.rdata = st.channel_config_low;
        can_glb_pkg::OFS_FIFO_IV: next_st.rdata = st.txrx_fifo_control_high;
        can_glb_pkg::OFS_STATUS: begin
          next_st.rdata = {15'h0000, grst, st.stamp};
        end
        default: next_st.rdata = 32'h0;
      endcase
    end
    if (req && wb_we) begin
      case (wb_adr)
        can_glb_pkg::OFS_CFG_LOW: begin
          if (grst) begin
            next_st.global_config_low = wb_merge(st.global_config_low, wb_dat_w, wb_sel,
                                                 can_glb_pkg::MASK_CFG_LOW);
          end
        end
        can_glb_pkg::OFS_CFG_HIGH: begin
          if (grst) begin
            next_st.global_config_high = wb_merge(st.global_config_high, wb_dat_w, wb_sel,
                                                  can_glb_pkg::MASK_CFG_HIGH);
          end
        end
        can_glb_pkg::OFS_CTRL: begin
          next_st.ctrl = wb_merge(st.ctrl, wb_dat_w, wb_sel, can_glb_pkg::MASK_CTRL);
        end
        can_glb_pkg::OFS_CH_CFG: begin
          next_st.channel_config_low = wb_merge(st.channel_config_low, wb_dat_w, wb_sel,
                                                can_glb_pkg::MASK_CH_CFG);
        end
        can_glb_pkg::OFS_FIFO_IV: begin
          next_st.txrx_fifo_control_high = wb_merge(st.txrx_fifo_control_high, wb_dat_w,
                                                    wb_sel, can_glb_pkg::MASK_FIFO_IV);
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.global_config_low <= can_glb_pkg::RST_CFG_LOW;
      st.global_config_high <= can_glb_pkg::RST_CFG_HIGH;
      st.ctrl <= can_glb_pkg::RST_CTRL;
      st.channel_config_low <= can_glb_pkg::RST_CH_CFG;
      st.txrx_fifo_control_high <= can_glb_pkg::RST_FIFO_IV;
    end else begin
      st <= next_st;
    end
  end

  assign wb_ack = st.ack;
  assign wb_dat_r = st.rdata;
  assign store_valid = st.st_valid;
  assign store_dlc = st.st_dlc;
  assign store_data = st.st_data;
  assign store_stamp = st.st_stamp;
  assign dlc_error = st.dlc_err;

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_no_replace_without_check;
    accept && !dlc_check_enable |=> store_valid && store_dlc == $past(msg_dlc);
  endproperty
  a_no_replace_without_check: assert property (p_no_replace_without_check)
    else $error("stored DLC differs from received DLC with check off");
  property p_replace;
    accept && dlc_check_enable && dlc_replace_enable && !short_dlc
      |=> store_dlc == $past(rule_dlc_value)
          && store_data == keep_bytes($past(msg_data), $past(rule_dlc_value));
  endproperty
  a_replace: assert property (p_replace)
    else $error("replacement did not store rule DLC or zeroed bytes");
  property p_keep_all;
    accept && dlc_check_enable && !dlc_replace_enable && !short_dlc
      |=> store_valid && store_data == $past(msg_data);
  endproperty
  a_keep_all: assert property (p_keep_all)
    else $error("received data not stored whole");
  property p_dlc_error;
    accept && dlc_check_enable && msg_dlc < rule_dlc_value
      |=> dlc_error && !store_valid;
  endproperty
  a_dlc_error: assert property (p_dlc_error)
    else $error("short DLC was not discarded with error");
  property p_mirror_own;
    msg_valid && rule_hit && msg_self && mirror_enable && rule_self_rx_select
      && !dlc_check_enable |=> store_valid;
  endproperty
  a_mirror_own: assert property (p_mirror_own)
    else $error("own frame lost with mirroring on");
  property p_other_rules;
    msg_valid && !msg_self && rule_self_rx_select |=> !store_valid && !dlc_error;
  endproperty
  a_other_rules: assert property (p_other_rules)
    else $error("other node frame used a self rule");
  property p_self_rules;
    msg_valid && msg_self && !(mirror_enable && rule_self_rx_select)
      |=> !store_valid && !dlc_error;
  endproperty
  a_self_rules: assert property (p_self_rules)
    else $error("own frame processed without mirror rule");
  // Watches the halved tick itself, so a source switch cannot trip it
  property p_half_clock;
    !can_clock_select && can_tick |=> !half_tick ##1 half_tick;
  endproperty
  a_half_clock: assert property (p_half_clock)
    else $error("halved clock tick not every other cycle");
  property p_sof_capture;
    msg_sof |=> st.sof_stamp == $past(st.stamp);
  endproperty
  a_sof_capture: assert property (p_sof_capture)
    else $error("timestamp not captured at SOF");
  property p_ts_halt;
    timestamp_source_select && !ch_run |=> st.stamp == $past(st.stamp);
  endproperty
  a_ts_halt: assert property (p_ts_halt)
    else $error("bit clock timestamp moved while channel stopped");

  property p_cfg_locked;
    wb_cyc && wb_stb && wb_we && !st.ack && !grst && wb_adr == can_glb_pkg::OFS_CFG_LOW
      |=> $stable(st.global_config_low);
  endproperty
  a_cfg_locked: assert property (p_cfg_locked)
    else $error("config changed outside global reset mode");

endmodule // can_global_rx

// ### dv/can_node_model.sv
// Far-side node model: presents frames to the controller and runs the X1 oscillator
`timescale 1ns/1ps
module can_node_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Frame request
  input wire logic go,
  input wire logic self,
  input wire logic [3:0] dlc,
  input wire logic [63:0] data,
  // Frame toward the controller
  output logic msg_sof,
  output logic msg_valid,
  output logic msg_self,
  output logic [3:0] msg_dlc,
  output logic [63:0] msg_data,
  output logic x1_clk
);
  logic x1_div;
  // ==========================================================
  // Oscillator at a quarter of sys_clk, below half the system clock
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      x1_div <= 1'b0;
      x1_clk <= 1'b0;
    end else begin
      x1_div <= ~x1_div;
      if (x1_div) x1_clk <= ~x1_clk;
    end
  end
  // ==========================================================
  // Start of frame, then the frame; fields scramble when idle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      msg_sof <= 1'b0;
      msg_valid <= 1'b0;
      msg_self <= 1'b0;
      msg_dlc <= 4'h0;
      msg_data <= 64'h0;
    end else begin
      msg_sof <= go;
      msg_valid <= msg_sof;
      if (msg_sof) begin
        msg_self <= self;
        msg_dlc <= dlc;
        msg_data <= data;
      end else begin
        msg_self <= ~msg_self;
        msg_dlc <= ~msg_dlc;
        msg_data <= ~msg_data;
      end
    end
  end
endmodule // can_node_model

// ### dv/can_global_rx_tb_top.sv
// Testbench for the CAN global receive and timing block
`timescale 1ns/1ps
module can_global_rx_tb_top;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat_w = 32'h0;
  logic go = 1'b0;
  logic self = 1'b0;
  logic rule_hit = 1'b0;
  logic rule_self_rx_select = 1'b0;
  logic [3:0] rule_dlc_value = 4'h0;
  logic [3:0] dlc = 4'h0;
  logic [63:0] data = 64'h0;
  logic [31:0] wb_dat_r, rd, r0, r1, r2;
  logic wb_ack, x1_clk, msg_sof, msg_valid, msg_self, store_valid, dlc_error;
  logic channel_quantum_clock, bit_tick, interval_tick;
  logic [3:0] msg_dlc, store_dlc;
  logic [63:0] msg_data, store_data;
  logic [15:0] store_stamp, last_s;
  int num_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  int last_c = -1;

  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;

  can_global_rx can_global_rx_inst (.sys_clk, .rst_n, .wb_cyc, .wb_stb, .wb_we, .wb_adr,
    .wb_sel, .wb_dat_w, .wb_dat_r, .wb_ack, .x1_clk, .msg_sof, .msg_valid, .msg_self,
    .msg_dlc, .msg_data, .rule_hit, .rule_self_rx_select, .rule_dlc_value, .store_valid,
    .store_dlc, .store_data, .store_stamp, .dlc_error, .channel_quantum_clock, .bit_tick,
    .interval_tick);
  can_node_model can_node_model_inst (.sys_clk, .rst_n, .go, .self, .dlc, .data, .msg_sof,
    .msg_valid, .msg_self, .msg_dlc, .msg_data, .x1_clk);

  // ==========================================================
  // Compare helpers
  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask
  task automatic near(input logic [31:0] got, input logic [31:0] exp);
    chk(got, (!$isunknown(got) && got + 1 >= exp && got <= exp + 1) ? got : exp);
  endtask
  task summarize;
    if (num_errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ==========================================================
  // Wishbone classic cycle
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat_w <= d;
    wb_sel <= 4'hf;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 40);
    chk(wb_ack, 1'b1);
    rd = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // ==========================================================
  // Rate measurements
  task automatic pulses(input int n, input int eq, input int eb, input int ei);
    int q, b, i;
    q = 0;
    b = 0;
    i = 0;
    repeat (n) begin
      @(negedge sys_clk);
      q += (channel_quantum_clock === 1'b1);
      b += (bit_tick === 1'b1);
      i += (interval_tick === 1'b1);
    end
    near(q, eq);
    near(b, eb);
    near(i, ei);
  endtask
  task automatic stamp(input int n, input int div);
    logic [15:0] s0;
    int c0;
    wb(1'b0, can_glb_pkg::OFS_STATUS, 32'h0);
    s0 = rd[15:0];
    c0 = cyc;
    repeat (n) @(posedge sys_clk);
    wb(1'b0, can_glb_pkg::OFS_STATUS, 32'h0);
    if (div == 0) chk(rd[15:0] - s0, 16'h0000);
    else near(16'(rd[15:0] - s0), (cyc - c0) / div);
  endtask
  // ==========================================================
  // One frame through acceptance, checked against the model
  task automatic send(input logic sf, input logic [3:0] dl, input logic [63:0] dt,
                      input logic hit, input logic rs, input logic [3:0] rdl,
                      input logic [2:0] md);
    logic [3:0] rx;
    logic [63:0] ed;
    int c;
    rx = md[0] ? rdl : 4'h0;
    @(posedge sys_clk);
    go <= 1'b1;
    self <= sf;
    dlc <= dl;
    data <= dt;
    rule_hit <= hit;
    rule_self_rx_select <= rs;
    rule_dlc_value <= rx;
    @(posedge sys_clk);
    go <= 1'b0;
    @(posedge sys_clk);
    c = cyc;
    @(posedge sys_clk);
    rule_hit <= 1'b0;
    rule_self_rx_select <= ~rs;
    rule_dlc_value <= ~rx;
    @(negedge sys_clk);
    ed = dt;
    if (!(hit && (sf ? (md[2] && rs) : !rs)))
      chk({store_valid, dlc_error}, 2'b00);
    else if (md[0] && rx != 4'h0 && dl < rx)
      chk({store_valid, dlc_error}, 2'b01);
    else begin
      if (md[0] && md[1]) for (int i = int'(rx); i < 8; i++) ed[8*i +: 8] = 8'h00;
      chk({store_valid, dlc_error, store_dlc, store_data},
          {2'b10, (md[0] && md[1]) ? rx : dl, ed});
      if (last_c >= 0) near(16'(store_stamp - last_s), (c - last_c) / 2);
      last_c = c;
      last_s = store_stamp;
    end
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(58751));
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    rdchk(can_glb_pkg::OFS_CFG_LOW, can_glb_pkg::RST_CFG_LOW);
    rdchk(can_glb_pkg::OFS_CFG_HIGH, can_glb_pkg::RST_CFG_HIGH);
    rdchk(can_glb_pkg::OFS_CH_CFG, can_glb_pkg::RST_CH_CFG);
    wb(1'b1, 8'h20, 32'hffff_ffff);
    rdchk(8'h20, 32'h0);
    wb(1'b1, can_glb_pkg::OFS_CH_CFG, 32'h0004_0001);
    wb(1'b1, can_glb_pkg::OFS_CFG_HIGH, 32'h0000_0003);
    wb(1'b1, can_glb_pkg::OFS_FIFO_IV, 32'h0000_0001);
    wb(1'b1, can_glb_pkg::OFS_CTRL, 32'h0000_0002);
    pulses(240, 60, 15, 20);
    wb(1'b1, can_glb_pkg::OFS_CFG_HIGH, 32'h0000_0005);
    wb(1'b1, can_glb_pkg::OFS_CFG_LOW, 32'h0000_0008);
    rdchk(can_glb_pkg::OFS_CFG_HIGH, 32'h0000_0003);
    rdchk(can_glb_pkg::OFS_CFG_LOW, 32'h0000_0000);
    wb(1'b1, can_glb_pkg::OFS_CTRL, 32'h0000_0001);
    wb(1'b1, can_glb_pkg::OFS_CFG_LOW, 32'h0000_0008);
    wb(1'b1, can_glb_pkg::OFS_CTRL, 32'h0000_0002);
    pulses(320, 40, 10, 26);
    wb(1'b1, can_glb_pkg::OFS_CTRL, 32'h0000_0001);
    wb(1'b1, can_glb_pkg::OFS_CFG_LOW, 32'h0000_0100);
    wb(1'b1, can_glb_pkg::OFS_CTRL, 32'h0000_0002);
    stamp(200, 4);
    wb(1'b1, can_glb_pkg::OFS_CTRL, 32'h0000_0001);
    wb(1'b1, can_glb_pkg::OFS_CH_CFG, 32'h0008_0000);
    wb(1'b1, can_glb_pkg::OFS_CFG_LOW, 32'h0000_0010);
    stamp(200, 0);
    wb(1'b1, can_glb_pkg::OFS_CTRL, 32'h0000_0003);
    stamp(320, 16);
    pulses(100, 50, 6, 0);
    for (int m = 0; m < 8; m++) begin
      wb(1'b1, can_glb_pkg::OFS_CTRL, 32'h0000_0001);
      wb(1'b1, can_glb_pkg::OFS_CFG_LOW, 32'(m));
      wb(1'b1, can_glb_pkg::OFS_CTRL, 32'h0000_0002);
      last_c = -1;
      repeat (24) begin
        r0 = $urandom;
        r1 = $urandom;
        r2 = $urandom;
        send(r0[0], r0[4:1], {r1, r2}, r0[5] | r0[6], r0[7], r0[11:8], 3'(m));
      end
    end
    summarize;
  end

  initial begin
    #200us;
    num_errors++;
    summarize;
  end
endmodule // can_global_rx_tb_top
